// ==== hdl/rpw_map.svh ====
// Purpose: Offsets, field positions, reset values and counts for the reset/power/watchdog block
// Assumes: Special function registers reached by an 8-bit address on the core's SFR port
// Notes:   Definitions only
`ifndef RPW_MAP_SVH
`define RPW_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define RPW_ADDR_POWER_CONTROL    8'h87
`define RPW_ADDR_WATCHDOG_CONTROL 8'h8f

// ****************************************
// Power control fields
// ****************************************
`define RPW_PC_POWER_OFF_BIT   4
`define RPW_PC_USER_HI_BIT     3
`define RPW_PC_USER_LO_BIT     2
`define RPW_PC_POWERDOWN_BIT   1
`define RPW_PC_IDLE_BIT        0
`define RPW_PC_WRITE_MASK      8'h1f
`define RPW_PC_RESET           8'h00

// ****************************************
// Watchdog control fields
// ****************************************
`define RPW_WD_ENABLE_BIT      7
`define RPW_WD_CLEAR_BIT       6
`define RPW_WD_IDLE_BIT        5
`define RPW_WD_SEL_MSB         2
`define RPW_WD_SEL_LSB         0
`define RPW_WD_RESET           8'h00

// ****************************************
// Reset values loaded into the core
// ****************************************
`define RPW_PORT_RESET         8'hff
`define RPW_STACK_RESET        8'h07
`define RPW_SFR_RESET          8'h00

// ****************************************
// Timing and divider figures
// ****************************************
`define RPW_STATES_PER_CYCLE   6
`define RPW_PHASES_PER_STATE   2
`define RPW_SAMPLE_STATE       4
`define RPW_SAMPLE_PHASE       1
`define RPW_RESET_MIN_CYCLES   2
`define RPW_DEGLITCH_LEN       3
`define RPW_WDT_BASE_TAP       9
`define RPW_WDT_STRETCH        4

`endif

// ==== hdl/rpw_pkg.sv ====
// Purpose: Types shared by the reset/power/watchdog block
// Assumes: Nothing beyond the map header
// Notes:   Gray codes along reset -> run -> idle -> asleep
package rpw_pkg;

  typedef enum logic [1:0] {
    RPW_ST_RESET = 2'b00,
    RPW_ST_RUN   = 2'b01,
    RPW_ST_IDLE  = 2'b11,
    RPW_ST_DOWN  = 2'b10
  } rpw_mode_type;

endpackage

// ==== hdl/rpw_divider_chain.sv ====
// Purpose: Free-running watchdog divider chain with a selectable tap
// Assumes: Advanced by one tick per machine cycle
// Notes:   Tap k raises the time-out on tick 2**(base+k)+1
`timescale 1ns/1ps
`include "rpw_map.svh"

module rpw_divider_chain
  import rpw_pkg::*;
#(
  parameter int CHAIN_WIDTH = 17
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] select,
  output logic            timeout
);

  logic [CHAIN_WIDTH-1:0] count_q;
  logic [CHAIN_WIDTH-1:0] count_d;
  logic                   timeout_q;
  logic                   timeout_d;
  logic [CHAIN_WIDTH-1:0] tap_mask;

  // ****************************************
  // Tap selection
  // ****************************************
  function automatic logic [CHAIN_WIDTH-1:0] tap_of(input logic [2:0] sel);
    logic [CHAIN_WIDTH-1:0] one;
    one    = {{(CHAIN_WIDTH-1){1'b0}}, 1'b1};
    tap_of = one << (`RPW_WDT_BASE_TAP + int'(sel));
  endfunction

  // ****************************************
  // Counting
  // ****************************************
  always_comb begin
    tap_mask  = tap_of(select);
    count_d   = count_q;
    timeout_d = 1'b0;
    if (clear) begin
      count_d = '0;
    end else if (run && tick) begin
      if ((count_q & tap_mask) != '0) begin
        timeout_d = 1'b1;
        count_d   = '0;
      end else begin
        count_d = count_q + {{(CHAIN_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= '0;
      timeout_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout = timeout_q;

endmodule

// ==== hdl/rpw_controller.sv ====
// Purpose: System reset, power-mode and watchdog controller of an 8-bit core
// Assumes: clk is the oscillator input; core reaches the SFRs at their own addresses
// Notes:   Watchdog time-out raises an internal reset equal to the pin reset
//
// How it works
// - Power-off flag at bit 4 set on power-up, software may clear it.
// - Reset clears power control to 00H except bit 4, which is kept.
// - Two user flag bits, freely read and written, no hardware effect.
// - Idle request stops the core clock; peripheral clock keeps running.
// - Interrupt or reset ends idle and restarts the core clock.
// - Power-down request stops every clock including the oscillator.
// - Only reset ends power-down; interrupts do not.
// - Reset pin sampled at S5P2; must stay high two machine cycles.
// - Short glitches on the reset pin are filtered out.
// - Reset loads ports FFH, stack 07H, other SFRs 00H, serial buffer kept.
// - Input clock halved before internal use.
// - Watchdog is a free-running divider chain with a selectable tap.
// - Watchdog time-out with reset enabled issues a system reset.
// - Any reset leaves the watchdog disabled until software enables it.
// - Watchdog control: enable bit 7, clear 6, run-in-idle 5, select 2..0.
// - Watchdog runs only while its enable bit is set.
// - Writing clear resets the divider chain counter only, not the cycle phase; bit returns to zero itself.
// - Watchdog runs in idle only with run-in-idle set; bit resets to zero.
// - Three-bit select field picks the divider tap and time-out.
// - Power-down request at bit 1, idle request bit 0, top three unused.
`timescale 1ns/1ps
`include "rpw_map.svh"

module rpw_controller
  import rpw_pkg::*;
#(
  parameter int CHAIN_WIDTH = 17
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reset_pin,
  input  wire logic       irq_pending,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_write,
  input  wire logic       sfr_read,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  output logic            sys_clk_en,
  output logic            core_clk_en,
  output logic            periph_clk_en,
  output logic            osc_enable,
  output logic            sys_reset,
  output logic      [7:0] port_reset_value,
  output logic      [7:0] stack_reset_value,
  output logic      [7:0] sfr_reset_value,
  output logic            serial_buffer_hold,
  output logic            idle_active,
  output logic            powerdown_active
);

  localparam int PHASE_CNT = `RPW_STATES_PER_CYCLE * `RPW_PHASES_PER_STATE;
  localparam int PHASE_W   = $clog2(PHASE_CNT);
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE =
    PHASE_W'(`RPW_SAMPLE_STATE * `RPW_PHASES_PER_STATE + `RPW_SAMPLE_PHASE);
  localparam logic [PHASE_W-1:0] LAST_PHASE = PHASE_W'(PHASE_CNT - 1);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic reset_sync1_q;
  logic reset_sync2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_sync1_q <= 1'b0;
      reset_sync2_q <= 1'b0;
    end else begin
      reset_sync1_q <= reset_pin;
      reset_sync2_q <= reset_sync1_q;
    end
  end

  // ****************************************
  // Clock halving and machine cycle phase
  // ****************************************
  logic               half_q;
  logic               half_d;
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;
  logic               sample_tick;
  logic               cycle_tick;
  rpw_mode_type       mode_q;
  rpw_mode_type       mode_d;

  always_comb begin
    half_d  = ~half_q;
    phase_d = phase_q;
    if (half_q) begin
      phase_d = (phase_q == LAST_PHASE) ? '0 : phase_q + PHASE_W'(1);
    end
    sample_tick = half_q && (phase_q == SAMPLE_PHASE);
    cycle_tick  = half_q && (phase_q == LAST_PHASE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_q  <= 1'b0;
      phase_q <= '0;
    end else begin
      half_q  <= half_d;
      phase_q <= phase_d;
    end
  end

  // ****************************************
  // Reset deglitch and qualification
  // ****************************************
  logic [`RPW_DEGLITCH_LEN-1:0] glitch_q;
  logic [`RPW_DEGLITCH_LEN-1:0] glitch_d;
  logic                         filt_q;
  logic                         filt_d;
  logic [1:0]                   held_q;
  logic [1:0]                   held_d;
  logic                         pin_reset;
  logic                         wdt_timeout;
  logic                         wdt_reset_q;
  logic                         wdt_reset_d;
  logic                         any_reset;

  always_comb begin
    glitch_d = {glitch_q[`RPW_DEGLITCH_LEN-2:0], reset_sync2_q};
    filt_d   = filt_q;
    if (&glitch_q) begin
      filt_d = 1'b1;
    end else if (~|glitch_q) begin
      filt_d = 1'b0;
    end
    held_d = held_q;
    if (sample_tick) begin
      if (!filt_q) begin
        held_d = 2'd0;
      end else if (held_q != 2'(`RPW_RESET_MIN_CYCLES)) begin
        held_d = held_q + 2'd1;
      end
    end
    pin_reset = (held_q == 2'(`RPW_RESET_MIN_CYCLES)) && filt_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glitch_q <= '0;
      filt_q   <= 1'b0;
      held_q   <= 2'd0;
    end else begin
      glitch_q <= glitch_d;
      filt_q   <= filt_d;
      held_q   <= held_d;
    end
  end

  // ****************************************
  // Registers and power modes
  // ****************************************
  logic [7:0] power_control_reg_q;
  logic [7:0] power_control_reg_d;
  logic [7:0] watchdog_ctrl_reg_q;
  logic [7:0] watchdog_ctrl_reg_d;
  logic       power_off_flag_q;
  logic       power_off_flag_d;
  logic       wr_power;
  logic       wr_watchdog;
  logic       wdt_clear;

  always_comb begin
    wr_power    = 1'b0;
    wr_watchdog = 1'b0;
    if (sfr_write && sfr_addr == `RPW_ADDR_POWER_CONTROL) begin
      wr_power = 1'b1;
    end else if (sfr_write && sfr_addr == `RPW_ADDR_WATCHDOG_CONTROL) begin
      wr_watchdog = 1'b1;
    end
    any_reset = pin_reset || wdt_reset_q;

    power_off_flag_d = power_off_flag_q;
    if (wr_power && !any_reset) begin
      power_off_flag_d = sfr_wdata[`RPW_PC_POWER_OFF_BIT];
    end

    power_control_reg_d = power_control_reg_q;
    if (any_reset) begin
      power_control_reg_d = `RPW_PC_RESET;
    end else if (wr_power) begin
      power_control_reg_d = sfr_wdata & `RPW_PC_WRITE_MASK;
    end else if (power_control_reg_q[`RPW_PC_IDLE_BIT] && irq_pending) begin
      power_control_reg_d[`RPW_PC_IDLE_BIT] = 1'b0;
    end

    wdt_clear           = 1'b0;
    watchdog_ctrl_reg_d = watchdog_ctrl_reg_q;
    if (any_reset) begin
      watchdog_ctrl_reg_d = `RPW_WD_RESET;
    end else if (wr_watchdog) begin
      watchdog_ctrl_reg_d = sfr_wdata;
      watchdog_ctrl_reg_d[4:3] = 2'b00;
      wdt_clear = sfr_wdata[`RPW_WD_CLEAR_BIT];
      watchdog_ctrl_reg_d[`RPW_WD_CLEAR_BIT] = 1'b0;
    end

    mode_d = mode_q;
    case (mode_q)
      RPW_ST_RESET: begin
        if (!any_reset) begin
          mode_d = RPW_ST_RUN;
        end
      end
      RPW_ST_RUN: begin
        if (any_reset) begin
          mode_d = RPW_ST_RESET;
        end else if (wr_power && sfr_wdata[`RPW_PC_POWERDOWN_BIT]) begin
          mode_d = RPW_ST_DOWN;
        end else if (wr_power && sfr_wdata[`RPW_PC_IDLE_BIT]) begin
          mode_d = RPW_ST_IDLE;
        end
      end
      RPW_ST_IDLE: begin
        if (any_reset) begin
          mode_d = RPW_ST_RESET;
        end else if (irq_pending) begin
          mode_d = RPW_ST_RUN;
        end
      end
      RPW_ST_DOWN: begin
        if (any_reset) begin
          mode_d = RPW_ST_RESET;
        end
      end
      default: begin
        mode_d = RPW_ST_RESET;
      end
    endcase
  end

  // Power-on flag is caught only by the power-on reset itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_off_flag_q    <= 1'b1;
      power_control_reg_q <= `RPW_PC_RESET;
      watchdog_ctrl_reg_q <= `RPW_WD_RESET;
      mode_q              <= RPW_ST_RESET;
    end else begin
      power_off_flag_q    <= power_off_flag_d;
      power_control_reg_q <= power_control_reg_d;
      watchdog_ctrl_reg_q <= watchdog_ctrl_reg_d;
      mode_q              <= mode_d;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  logic wdt_run;
  logic [`RPW_WDT_STRETCH-1:0] wdt_hold_q;
  logic [`RPW_WDT_STRETCH-1:0] wdt_hold_d;

  always_comb begin
    wdt_run = watchdog_ctrl_reg_q[`RPW_WD_ENABLE_BIT] && (mode_q == RPW_ST_RUN ||
              (mode_q == RPW_ST_IDLE && watchdog_ctrl_reg_q[`RPW_WD_IDLE_BIT]));
    wdt_hold_d = wdt_hold_q;
    if (wdt_timeout && watchdog_ctrl_reg_q[`RPW_WD_ENABLE_BIT]) begin
      wdt_hold_d = '1;
    end else if (wdt_hold_q != '0) begin
      wdt_hold_d = wdt_hold_q - `RPW_WDT_STRETCH'(1);
    end
    wdt_reset_d = (wdt_hold_d != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_hold_q  <= '0;
      wdt_reset_q <= 1'b0;
    end else begin
      wdt_hold_q  <= wdt_hold_d;
      wdt_reset_q <= wdt_reset_d;
    end
  end

  rpw_divider_chain #(
    .CHAIN_WIDTH (CHAIN_WIDTH)
  ) u_chain (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (cycle_tick),
    .run     (wdt_run),
    .clear   (wdt_clear || any_reset),
    .select  (watchdog_ctrl_reg_q[`RPW_WD_SEL_MSB:`RPW_WD_SEL_LSB]),
    .timeout (wdt_timeout)
  );

  // ****************************************
  // Outputs
  // ****************************************
  logic [7:0] rdata_d;
  logic       hit_d;

  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b0;
    if (sfr_read && sfr_addr == `RPW_ADDR_POWER_CONTROL) begin
      rdata_d = power_control_reg_q;
      rdata_d[`RPW_PC_POWER_OFF_BIT] = power_off_flag_q;
      hit_d = 1'b1;
    end else if (sfr_read && sfr_addr == `RPW_ADDR_WATCHDOG_CONTROL) begin
      rdata_d = watchdog_ctrl_reg_q;
      hit_d   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata          <= 8'h00;
      sfr_hit            <= 1'b0;
      sys_clk_en         <= 1'b0;
      core_clk_en        <= 1'b0;
      periph_clk_en      <= 1'b0;
      osc_enable         <= 1'b1;
      sys_reset          <= 1'b1;
      port_reset_value   <= `RPW_PORT_RESET;
      stack_reset_value  <= `RPW_STACK_RESET;
      sfr_reset_value    <= `RPW_SFR_RESET;
      serial_buffer_hold <= 1'b1;
      idle_active        <= 1'b0;
      powerdown_active   <= 1'b0;
    end else begin
      sfr_rdata          <= rdata_d;
      sfr_hit            <= hit_d;
      sys_clk_en         <= half_d && (mode_d != RPW_ST_DOWN);
      core_clk_en        <= half_d && (mode_d == RPW_ST_RUN || mode_d == RPW_ST_RESET);
      periph_clk_en      <= half_d && (mode_d != RPW_ST_DOWN);
      osc_enable         <= (mode_d != RPW_ST_DOWN);
      sys_reset          <= any_reset;
      port_reset_value   <= `RPW_PORT_RESET;
      stack_reset_value  <= `RPW_STACK_RESET;
      sfr_reset_value    <= `RPW_SFR_RESET;
      serial_buffer_hold <= 1'b1;
      idle_active        <= (mode_d == RPW_ST_IDLE);
      powerdown_active   <= (mode_d == RPW_ST_DOWN);
    end
  end

endmodule

// ==== tb/rpw_controller_chk.sv ====
// Purpose: Port assertions for the reset/power/watchdog controller
// Assumes: Single clock domain, rst_n asynchronous active low
// Notes:   Bound to every rpw_controller instance
`timescale 1ns/1ps
module rpw_controller_chk
  import rpw_pkg::*;
#(
  parameter int CHAIN_WIDTH = 17
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       irq_pending,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       sys_clk_en,
  input wire logic       core_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_enable,
  input wire logic       sys_reset,
  input wire logic [7:0] port_reset_value,
  input wire logic [7:0] stack_reset_value,
  input wire logic [7:0] sfr_reset_value,
  input wire logic       serial_buffer_hold,
  input wire logic       idle_active,
  input wire logic       powerdown_active
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HALF_CLK: assert property (sys_clk_en |=> !sys_clk_en)
    else $error("system clock enable high two cycles running");
  AST_CORE_IDLE: assert property (idle_active && $past(idle_active) |-> !core_clk_en)
    else $error("core clock enabled in idle");
  AST_PERIPH_IDLE: assert property (idle_active [*3] |-> periph_clk_en || $past(periph_clk_en))
    else $error("peripheral clock stopped in idle");
  AST_IDLE_EXIT: assert property (idle_active && irq_pending |-> ##[1:2] !idle_active)
    else $error("interrupt did not end idle");
  AST_DOWN_CLOCKS: assert property (powerdown_active && $past(powerdown_active)
    |-> !osc_enable && !sys_clk_en && !core_clk_en && !periph_clk_en)
    else $error("clock running in power-down");
  AST_DOWN_EXIT: assert property ($fell(powerdown_active) |-> ##[0:2] sys_reset)
    else $error("power-down left without reset");
  AST_CONSTS: assert property ($past(rst_n, 2) |-> port_reset_value == 8'hff
    && stack_reset_value == 8'h07 && sfr_reset_value == 8'h00 && serial_buffer_hold)
    else $error("reset value exports wrong");
  AST_HIT: assert property (sfr_read && (sfr_addr == 8'h87 || sfr_addr == 8'h8f) |=> sfr_hit)
    else $error("mapped read without hit");
  AST_MISS: assert property (sfr_read && sfr_addr != 8'h87 && sfr_addr != 8'h8f
    |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  AST_WD_FIELDS: assert property (sfr_read && sfr_addr == 8'h8f |=> (sfr_rdata & 8'h58) == 8'h00)
    else $error("watchdog clear or unused bits read nonzero");
  AST_PC_FIELDS: assert property (sfr_read && sfr_addr == 8'h87 |=> sfr_rdata[7:5] == 3'h0)
    else $error("power control unused bits nonzero");
endmodule

bind rpw_controller rpw_controller_chk #(.CHAIN_WIDTH(CHAIN_WIDTH)) u_chk (
  .clk(clk), .rst_n(rst_n), .irq_pending(irq_pending), .sfr_addr(sfr_addr),
  .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sys_clk_en(sys_clk_en),
  .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
  .sys_reset(sys_reset), .port_reset_value(port_reset_value),
  .stack_reset_value(stack_reset_value), .sfr_reset_value(sfr_reset_value),
  .serial_buffer_hold(serial_buffer_hold), .idle_active(idle_active),
  .powerdown_active(powerdown_active)
);

// ==== tb/rpw_controller_tb.sv ====
// Purpose: Self-checking bench for the reset/power/watchdog controller
// Assumes: Inputs driven at the falling clock edge
// Notes:   Watchdog tests use the shortest select codes
`timescale 1ns/1ps
module rpw_controller_tb;
  import rpw_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n, reset_pin, irq_pending, sfr_write, sfr_read;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port_rv, stack_rv, sfr_rv;
  logic       sfr_hit, sys_clk_en, core_clk_en, periph_clk_en, osc_enable;
  logic       sys_reset, sb_hold, idle_active, powerdown_active;
  int         err_count = 0;
  int         compares = 0;
  int         cycles = 0;

  always #2 clk = ~clk;

  rpw_controller #(.CHAIN_WIDTH(17)) u_dut (
    .clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .irq_pending(irq_pending),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sys_clk_en(sys_clk_en),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .sys_reset(sys_reset), .port_reset_value(port_rv), .stack_reset_value(stack_rv),
    .sfr_reset_value(sfr_rv), .serial_buffer_hold(sb_hold), .idle_active(idle_active),
    .powerdown_active(powerdown_active)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1'b1;
    @(negedge clk);
    sfr_write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_read = 1'b1;
    @(negedge clk);
    sfr_read = 1'b0;
    check(sfr_rdata, e, "read data");
    check({7'h00, sfr_hit}, {7'h00, a == 8'h87 || a == 8'h8f}, "hit");
  endtask

  task automatic wait_rst(input logic v, input int max);
    int n;
    n = 0;
    while (sys_reset !== v && n < max) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, sys_reset}, {7'h00, v}, "system reset");
  endtask

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(negedge clk);
      if (sys_reset !== 1'b0) hits++;
    end
    check({7'h00, hits != 0}, 8'h00, "unexpected reset");
  endtask

  task automatic pin_reset();
    reset_pin = 1'b1;
    wait_rst(1'b1, 100);
    tick(20);
    reset_pin = 1'b0;
    wait_rst(1'b0, 60);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_por();
    rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick(2);
    rd(8'h87, 8'h10);
    rd(8'h8f, 8'h00);
    rd(8'h88, 8'h00);
    check(port_rv, 8'hff, "port value");
    check(stack_rv, 8'h07, "stack value");
    check(sfr_rv, 8'h00, "sfr value");
    check({7'h00, sb_hold}, 8'h01, "serial buffer hold");
  endtask

  task automatic t_regs();
    wr(8'h87, 8'h1c);
    rd(8'h87, 8'h1c);
    wr(8'h87, 8'h00);
    rd(8'h87, 8'h00);
    wr(8'h8f, 8'hff);
    rd(8'h8f, 8'ha7);
    wr(8'h8f, 8'h00);
  endtask

  task automatic t_pin();
    wr(8'h87, 8'h1c);
    wr(8'h8f, 8'h05);
    reset_pin = 1'b1;
    tick(2);
    reset_pin = 1'b0;
    quiet(150);
    rd(8'h87, 8'h1c);
    pin_reset();
    rd(8'h87, 8'h10);
    rd(8'h8f, 8'h00);
  endtask

  task automatic t_idle();
    int c;
    int p;
    int s;
    c = 0;
    p = 0;
    s = 0;
    wr(8'h87, 8'h11);
    tick(2);
    check({7'h00, idle_active}, 8'h01, "idle");
    repeat (24) begin
      @(negedge clk);
      if (core_clk_en !== 1'b0) c++;
      if (periph_clk_en === 1'b1) p++;
      if (sys_clk_en === 1'b1) s++;
    end
    check(c[7:0], 8'h00, "core clock");
    check(p[7:0], 8'h0c, "peripheral clock");
    check(s[7:0], 8'h0c, "system clock halved");
    irq_pending = 1'b1;
    tick(3);
    irq_pending = 1'b0;
    check({7'h00, idle_active}, 8'h00, "idle exit");
    rd(8'h87, 8'h10);
  endtask

  task automatic t_down();
    wr(8'h87, 8'h12);
    tick(3);
    check({6'h00, powerdown_active, osc_enable}, 8'h02, "power-down");
    irq_pending = 1'b1;
    tick(50);
    irq_pending = 1'b0;
    check({7'h00, powerdown_active}, 8'h01, "still down");
    pin_reset();
    check({7'h00, powerdown_active}, 8'h00, "woken");
    rd(8'h87, 8'h10);
  endtask

  task automatic t_wd_idle();
    wr(8'h8f, 8'h80);
    wr(8'h87, 8'h11);
    quiet(14000);
    irq_pending = 1'b1;
    tick(3);
    irq_pending = 1'b0;
    quiet(12000);
    wait_rst(1'b1, 1000);
    wait_rst(1'b0, 40);
    rd(8'h8f, 8'h00);
    rd(8'h87, 8'h10);
  endtask

  task automatic t_wd_clear();
    wr(8'h8f, 8'h80);
    repeat (2) begin
      quiet(10000);
      wr(8'h8f, 8'hc0);
    end
    wr(8'h8f, 8'hc1);
    quiet(20000);
    wait_rst(1'b1, 5000);
    wait_rst(1'b0, 40);
    rd(8'h8f, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    reset_pin = 1'b0;
    irq_pending = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_write = 1'b0;
    sfr_read = 1'b0;
    t_por();
    t_regs();
    t_pin();
    t_idle();
    t_down();
    t_wd_idle();
    t_wd_clear();
    wr(8'h87, 8'h00);
    t_por();
    summarize();
  end
endmodule
